/* dv/secl_loader_bench.sv */
// Self-checking bench for the serial configuration loader.
`timescale 1ns/100ps

module secl_loader_bench;
  logic       clk_in;
  logic       rst_in;
  logic       ce_in;
  logic       ee_sel_out;
  logic       ee_clk_out;
  logic       ee_mosi_out;
  logic       ee_miso_in;
  logic       phy_disconnect_out;
  logic       ee_present_out;
  logic       desc_rd_in;
  logic [8:0] desc_addr_in;
  logic [7:0] desc_rdata_out;
  logic       desc_rvalid_out;
  logic       desc_default_out;
  logic       swcfg_present_out;
  logic [7:0] swcfg_len_out;
  logic [8:0] swcfg_addr_out;
  logic       host_valid_in;
  logic       host_ready_out;
  logic [1:0] host_op_in;
  logic [8:0] host_addr_in;
  logic [7:0] host_wdata_in;
  logic       host_rvalid_out;
  logic       host_rready_in;
  logic [7:0] host_rdata_out;
  int         error_cnt = 0;
  int         compares = 0;
  int         cyc = 0;

  // A short programming limit keeps write and erase polls brief.
  secl_loader #(.BUSY_CYC(2000)) DUT (.*);
  secl_mem_model #(.BUSY_NS(1500)) u_mem (.ee_sel_in(ee_sel_out), .ee_clk_in(ee_clk_out),
    .ee_di_in(ee_mosi_out), .ee_do_out(ee_miso_in));

  always #2.5 clk_in = ~clk_in;

  // A full signed load is far beyond this ceiling, so it is only sampled.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      error_cnt++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick

  task automatic do_reset;
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
  endtask : do_reset

  task automatic wait_reads(input int target);
    while (u_mem.rd_cnt < target) @(negedge clk_in);
  endtask : wait_reads

  // Request held until an edge samples ready high.
  task automatic host_req(input logic [1:0] op, input logic [8:0] addr, input logic [7:0] data);
    @(posedge clk_in);
    host_valid_in <= 1'b1;
    host_op_in <= op;
    host_addr_in <= addr;
    host_wdata_in <= data;
    @(negedge clk_in);
    while (host_ready_out !== 1'b1) @(negedge clk_in);
    @(posedge clk_in);
    host_valid_in <= 1'b0;
  endtask : host_req

  task automatic host_pop(input logic [7:0] exp);
    @(negedge clk_in);
    while (host_rvalid_out !== 1'b1) @(negedge clk_in);
    check(host_rdata_out, exp);
    @(posedge clk_in);
    host_rready_in <= 1'b1;
    @(posedge clk_in);
    host_rready_in <= 1'b0;
  endtask : host_pop

  // Descriptor strobe for one edge, answer judged in the cycle after.
  task automatic desc_read(input logic [8:0] addr, input logic [7:0] exp);
    @(posedge clk_in);
    desc_rd_in <= 1'b1;
    desc_addr_in <= addr;
    @(posedge clk_in);
    desc_rd_in <= 1'b0;
    @(negedge clk_in);
    check(desc_rvalid_out, 1'b1);
    check(desc_rdata_out, exp);
  endtask : desc_read

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // signed load, restarted
  task automatic sc_signed;
    tick(1);
    u_mem.mem[0] = 8'hA5;
    do_reset();
    wait_reads(6);
    tick(1000);
    check(phy_disconnect_out, 1'b1);
    check(host_ready_out, 1'b0);
    check(ee_present_out, 1'b1);
    check(u_mem.last_addr, 9'h005);
    desc_read(9'h000, 8'hA5);
    desc_read(9'h005, 8'h05);
    do_reset();
    wait_reads(7);
    check(u_mem.last_addr, 9'h000);
  endtask : sc_signed

  task automatic sc_blank;
    int n;
    u_mem.mem[0] = 8'h3C;
    do_reset();
    n = u_mem.rd_cnt;
    while (phy_disconnect_out !== 1'b0) @(negedge clk_in);
    check(16'(u_mem.rd_cnt - n), 16'h0001);
    check(ee_present_out, 1'b0);
    check(desc_default_out, 1'b1);
    check(swcfg_present_out, 1'b0);
    check(swcfg_len_out, secl_pkg::SWCFG_LEN_DF);
    check(swcfg_addr_out, secl_pkg::SWCFG_ADR_DF);
    @(posedge clk_in);
    desc_rd_in <= 1'b1;
    desc_addr_in <= 9'h014;
    @(posedge clk_in);
    desc_rd_in <= 1'b0;
    @(negedge clk_in);
    check(desc_rvalid_out, 1'b1);
    // A low clock enable freezes the port, so a held strobe gets no answer.
    @(posedge clk_in);
    ce_in <= 1'b0;
    desc_rd_in <= 1'b1;
    tick(3);
    check(desc_rvalid_out, 1'b0);
    @(posedge clk_in);
    ce_in <= 1'b1;
    desc_rd_in <= 1'b0;
  endtask : sc_blank

  task automatic sc_fill;
    u_mem.mem[9'h055] = 8'h96;
    u_mem.mem[9'h1FF] = 8'h71;
    host_req(secl_pkg::HOP_READ, 9'h055, 8'h00);
    host_req(secl_pkg::HOP_READ, 9'h1FF, 8'h00);
    tick(4400);
    check(host_ready_out, 1'b0);
    host_pop(8'h96);
    host_pop(8'h71);
    tick(1);
    check(host_rvalid_out, 1'b0);
  endtask : sc_fill

  // write and erase, each read back
  task automatic sc_prog;
    host_req(secl_pkg::HOP_WRITE, 9'h0A5, 8'h5A);
    host_req(secl_pkg::HOP_READ, 9'h0A5, 8'h00);
    host_pop(8'h5A);
    host_req(secl_pkg::HOP_ERASE, 9'h0A5, 8'h00);
    host_req(secl_pkg::HOP_READ, 9'h0A5, 8'h00);
    host_pop(8'hFF);
    check(u_mem.mem[9'h0A5], 8'hFF);
  endtask : sc_prog

  initial begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    ce_in = 1'b1;
    desc_rd_in = 1'b0;
    desc_addr_in = 9'h000;
    host_valid_in = 1'b0;
    host_op_in = 2'h0;
    host_addr_in = 9'h000;
    host_wdata_in = 8'h00;
    host_rready_in = 1'b0;
    sc_signed();
    sc_blank();
    sc_fill();
    sc_prog();
    final_report();
  end
endmodule : secl_loader_bench

/* dv/secl_loader_chk.sv */
// Port timing checker for the serial configuration loader.
`timescale 1ns/100ps

module secl_loader_chk (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       ce_in,
  input wire logic       ee_sel_out,
  input wire logic       ee_clk_out,
  input wire logic       ee_mosi_out,
  input wire logic       phy_disconnect_out,
  input wire logic       ee_present_out,
  input wire logic       desc_rd_in,
  input wire logic       desc_rvalid_out,
  input wire logic       desc_default_out,
  input wire logic       swcfg_present_out,
  input wire logic [7:0] swcfg_len_out,
  input wire logic [8:0] swcfg_addr_out,
  input wire logic       host_ready_out,
  input wire logic       host_rvalid_out,
  input wire logic       host_rready_in,
  input wire logic [7:0] host_rdata_out
);
  // ----------------------------------------------------------------
  // Link timing helpers
  // ----------------------------------------------------------------
  logic [7:0] gap_cnt;
  logic [7:0] half_cnt;
  logic       prev_clk;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Low time of the select; reset saturates it so the first frame is not judged.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      gap_cnt <= 8'hFF;
    end else if (ee_sel_out) begin
      gap_cnt <= 8'h00;
    end else if (ce_in && gap_cnt != 8'hFF) begin
      gap_cnt <= gap_cnt + 8'h01;
    end
  end

  // Cycles that the memory clock has held its level.
  always_ff @(posedge clk_in) begin
    prev_clk <= ee_clk_out;
    if (rst_in) begin
      half_cnt <= 8'hFF;
    end else if (ee_clk_out != prev_clk) begin
      half_cnt <= 8'h00;
    end else if (ce_in && half_cnt != 8'hFF) begin
      half_cnt <= half_cnt + 8'h01;
    end
  end

  a_load_blocks_host: assert property (phy_disconnect_out |-> !host_ready_out)
    else $error("Host port open while the load runs.");
  a_connect_idle_link: assert property ($fell(phy_disconnect_out) |-> !ee_sel_out)
    else $error("PHY released during a frame.");
  a_sel_idle_clk: assert property (!ee_sel_out |-> !ee_clk_out)
    else $error("Memory clock high while deselected.");
  a_clk_half_hold: assert property (ee_clk_out != prev_clk |-> half_cnt >= 8'h63)
    else $error("Memory clock level held too briefly.");
  a_sel_gap_min: assert property ($rose(ee_sel_out) |-> gap_cnt >= 8'h63)
    else $error("Gap between frames too short.");
  a_mosi_steady: assert property (ee_clk_out && prev_clk |-> $stable(ee_mosi_out))
    else $error("Data to memory moved while its clock was high.");
  a_desc_answer: assert property (desc_rd_in && ce_in |=> desc_rvalid_out)
    else $error("Descriptor read not answered next cycle.");
  a_desc_no_spur: assert property (desc_rvalid_out |-> $past(desc_rd_in))
    else $error("Descriptor answer without a read.");
  a_default_needs_sig: assert property (!desc_default_out |-> ee_present_out)
    else $error("Image used without a signature.");
  a_swcfg_word: assert property (swcfg_addr_out[0] == 1'b0)
    else $error("Structure address is not a word offset.");
  a_swcfg_zero_len: assert property (swcfg_present_out |-> swcfg_len_out != 8'h00)
    else $error("Zero length field taken as present.");
  a_answer_holds: assert property (host_rvalid_out && !host_rready_in |=>
    host_rvalid_out && $stable(host_rdata_out))
    else $error("Read answer lost while stalled.");

  c_desc_read: cover property (desc_rvalid_out);
  c_host_pop: cover property (host_rvalid_out && host_rready_in);
  c_connect: cover property ($fell(phy_disconnect_out));
endmodule : secl_loader_chk

bind secl_loader secl_loader_chk u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .ee_sel_out(ee_sel_out),
  .ee_clk_out(ee_clk_out), .ee_mosi_out(ee_mosi_out), .phy_disconnect_out(phy_disconnect_out),
  .ee_present_out(ee_present_out), .desc_rd_in(desc_rd_in), .desc_rvalid_out(desc_rvalid_out),
  .desc_default_out(desc_default_out), .swcfg_present_out(swcfg_present_out),
  .swcfg_len_out(swcfg_len_out), .swcfg_addr_out(swcfg_addr_out),
  .host_ready_out(host_ready_out), .host_rvalid_out(host_rvalid_out),
  .host_rready_in(host_rready_in), .host_rdata_out(host_rdata_out)
);

/* dv/secl_mem_model.sv */
// Behavioural three-wire serial memory of 512 bytes.
`timescale 1ns/100ps

module secl_mem_model #(
  parameter int BUSY_NS = 1500
) (
  input  wire logic ee_sel_in,
  input  wire logic ee_clk_in,
  input  wire logic ee_di_in,
  output logic      ee_do_out
);
  logic [7:0]  mem [0:511];
  logic [11:0] cmd;
  logic [7:0]  dat;
  logic [8:0]  last_addr;
  logic        wen;
  logic        busy;
  int          k;
  int          rd_cnt;

  // Address ramp as content; the bench overwrites the bytes it needs.
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = i[7:0];
    end
    ee_do_out = 1'b0;
    wen = 1'b0;
    busy = 1'b0;
    k = 0;
    rd_cnt = 0;
    last_addr = 9'h000;
  end

  // Selection shows the ready status, low while programming.
  always @(posedge ee_sel_in) begin
    k = 0;
    ee_do_out = ~busy;
  end

  always @(negedge busy) begin
    if (ee_sel_in) begin
      ee_do_out = 1'b1;
    end
  end

  always @(posedge ee_clk_in) begin
    if (ee_sel_in) begin
      k = k + 1;
      if (k <= 12) begin
        cmd = {cmd[10:0], ee_di_in};
      end else begin
        dat = {dat[6:0], ee_di_in};
      end
      if (k > 12 && k <= 20 && cmd[11:9] == secl_pkg::OPC_READ) begin
        ee_do_out = mem[cmd[8:0]][20 - k];
      end
    end
  end

  always @(negedge ee_sel_in) begin
    if (k == 20 && cmd[11:9] == secl_pkg::OPC_READ) begin
      rd_cnt = rd_cnt + 1;
      last_addr = cmd[8:0];
    end
    if (k == 12 && cmd[11:7] == {secl_pkg::OPC_EWEN, 2'b11}) begin
      wen = 1'b1;
    end
    if (wen && ((k == 20 && cmd[11:9] == secl_pkg::OPC_WRITE) ||
                (k == 12 && cmd[11:9] == secl_pkg::OPC_ERASE))) begin
      mem[cmd[8:0]] = (k == 20) ? dat : 8'hFF;
      busy = 1'b1;
      busy <= #(BUSY_NS) 1'b0;
    end
    // A released line never keeps its last bit, so a stale sample shows.
    ee_do_out = ~ee_do_out;
  end
endmodule : secl_mem_model

/* verilog/secl_loader.sv */
// Serial configuration memory loader with host access and descriptor read port.
// Functional notes
// - Every system reset starts a fresh load.
// - Memory present only if byte zero is A5.
// - Copy whole memory into internal 512 byte SRAM.
// - Descriptor values are read from the SRAM copy.
// - PHY held disconnected until loading completes.
// - Host may read, write and erase memory.
// - Image offsets count 16-bit words.
// - Zero length field means use default.
`timescale 1ns/100ps

module secl_loader #(
  parameter int BUSY_CYC = secl_pkg::EE_BUSY_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  // Serial memory pins.
  output logic            ee_sel_out,
  output logic            ee_clk_out,
  output logic            ee_mosi_out,
  input  wire logic       ee_miso_in,
  // Status toward the USB core.
  output logic            phy_disconnect_out,
  output logic            ee_present_out,
  // Descriptor read port into the SRAM copy.
  input  wire logic       desc_rd_in,
  input  wire logic [8:0] desc_addr_in,
  output logic      [7:0] desc_rdata_out,
  output logic            desc_rvalid_out,
  output logic            desc_default_out,
  // Software configuration field, decoded from the image.
  output logic            swcfg_present_out,
  output logic      [7:0] swcfg_len_out,
  output logic      [8:0] swcfg_addr_out,
  // Host operation request.
  input  wire logic       host_valid_in,
  output logic            host_ready_out,
  input  wire logic [1:0] host_op_in,
  input  wire logic [8:0] host_addr_in,
  input  wire logic [7:0] host_wdata_in,
  // Host read answer, through a two-entry buffer.
  output logic            host_rvalid_out,
  input  wire logic       host_rready_in,
  output logic      [7:0] host_rdata_out
);

  // ---------------------------------------------------------------------------
  // Pin synchroniser and bit clock divider
  // ---------------------------------------------------------------------------
  logic        miso_meta;
  logic        miso_s;
  logic [6:0]  div;
  logic        tick;

  // Two flops before any logic looks at the memory data pin.
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      miso_meta <= ee_miso_in;
      miso_s    <= miso_meta;
    end
  end

  assign tick = (div == 7'(secl_pkg::EE_HALF_CYC - 1));

  // Free-running half period timer; every action on the pins but the frame preload in ST_LOAD waits for it.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div <= 7'h00;
    end else if (ce_in) begin
      div <= tick ? 7'h00 : div + 7'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------------------
  secl_pkg::secl_state_e state;
  logic [19:0] frame;
  logic [4:0]  nclk;
  logic [4:0]  cnt;
  logic        rd_frame;
  logic        poll;
  logic        pend_ewen;
  logic        loading;
  logic        loaded;
  logic [8:0]  load_addr;
  logic [7:0]  rx;
  logic [1:0]  op;
  logic [8:0]  op_addr;
  logic [7:0]  op_data;
  logic [31:0] busy_cnt;
  logic        push;
  logic        fifo_full;
  logic        sram_wr;
  logic        accept;

  // Requests are taken only on a divider tick, so select keeps its full low time.
  assign accept         = (state == secl_pkg::ST_IDLE) && host_valid_in && !fifo_full && tick;
  assign host_ready_out = (state == secl_pkg::ST_IDLE) && !fifo_full && tick;
  assign ee_mosi_out    = frame[19];

  // Frame contents come from flops, so the data pin never glitches.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state      <= secl_pkg::ST_LOAD;
      loading    <= 1'b1;
      loaded     <= 1'b0;
      ee_sel_out <= 1'b0;
      ee_clk_out <= 1'b0;
      frame      <= 20'h00000;
      nclk       <= 5'h00;
      cnt        <= 5'h00;
      rd_frame   <= 1'b0;
      poll       <= 1'b0;
      pend_ewen  <= 1'b0;
      rx         <= 8'h00;
      op         <= 2'h0;
      op_addr    <= 9'h000;
      op_data    <= 8'h00;
      busy_cnt   <= 32'h00000000;
      push       <= 1'b0;
      sram_wr    <= 1'b0;
    end else if (ce_in) begin
      push    <= 1'b0;
      sram_wr <= 1'b0;
      case (state)
        secl_pkg::ST_LOAD: begin
          frame    <= {secl_pkg::OPC_READ, load_addr, 8'h00};
          nclk     <= secl_pkg::CLKS_LONG;
          rd_frame <= 1'b1;
          poll     <= 1'b0;
          if (tick) begin
            ee_sel_out <= 1'b1;
            cnt        <= 5'h00;
            state      <= secl_pkg::ST_XFER;
          end
        end
        secl_pkg::ST_IDLE: begin
          if (accept) begin
            op        <= host_op_in;
            op_addr   <= host_addr_in;
            op_data   <= host_wdata_in;
            rd_frame  <= (host_op_in == secl_pkg::HOP_READ);
            poll      <= 1'b0;
            pend_ewen <= (host_op_in != secl_pkg::HOP_READ);
            cnt       <= 5'h00;
            if (host_op_in == secl_pkg::HOP_READ) begin
              frame <= {secl_pkg::OPC_READ, host_addr_in, 8'h00};
              nclk  <= secl_pkg::CLKS_LONG;
            end else begin
              // Programming needs the write enable frame first.
              frame <= {secl_pkg::OPC_EWEN, secl_pkg::EWEN_ADDR, 8'h00};
              nclk  <= secl_pkg::CLKS_SHORT;
            end
            ee_sel_out <= 1'b1;
            state      <= secl_pkg::ST_XFER;
          end
        end
        secl_pkg::ST_XFER: begin
          // Rise with data stable, fall to sample and advance.
          if (tick) begin
            if (!ee_clk_out) begin
              ee_clk_out <= 1'b1;
            end else begin
              ee_clk_out <= 1'b0;
              cnt        <= cnt + 5'h01;
              frame      <= {frame[18:0], 1'b0};
              // The dummy bit after the address is skipped by sampling from clock 13.
              if (rd_frame && (cnt >= secl_pkg::CLKS_SHORT)) begin
                rx <= {rx[6:0], miso_s};
              end
              if (cnt == nclk - 5'h01) begin
                ee_sel_out <= 1'b0;
                state      <= secl_pkg::ST_GAP;
              end
            end
          end
        end
        secl_pkg::ST_GAP: begin
          // Select stays low a full half period between frames.
          if (tick) begin
            cnt <= 5'h00;
            if (pend_ewen) begin
              pend_ewen  <= 1'b0;
              poll       <= 1'b1;
              ee_sel_out <= 1'b1;
              state      <= secl_pkg::ST_XFER;
              if (op == secl_pkg::HOP_WRITE) begin
                frame <= {secl_pkg::OPC_WRITE, op_addr, op_data};
                nclk  <= secl_pkg::CLKS_LONG;
              end else begin
                frame <= {secl_pkg::OPC_ERASE, op_addr, 8'h00};
                nclk  <= secl_pkg::CLKS_SHORT;
              end
            end else if (poll) begin
              ee_sel_out <= 1'b1;
              busy_cnt   <= 32'h00000000;
              state      <= secl_pkg::ST_POLL;
            end else begin
              state <= secl_pkg::ST_DONE;
            end
          end
        end
        secl_pkg::ST_POLL: begin
          // Data pin goes high when programming ends; a dead part times out.
          // Both exits wait for a tick, so the next select still sees a full gap.
          busy_cnt <= busy_cnt + 32'h00000001;
          if (tick && (miso_s || (busy_cnt >= 32'(BUSY_CYC)))) begin
            ee_sel_out <= 1'b0;
            poll       <= 1'b0;
            state      <= secl_pkg::ST_IDLE;
          end
        end
        secl_pkg::ST_DONE: begin
          if (loading) begin
            if ((load_addr == secl_pkg::SIG_ADDR) && (rx != secl_pkg::SIGNATURE)) begin
              loading <= 1'b0;
              loaded  <= 1'b1;
              state   <= secl_pkg::ST_IDLE;
            end else begin
              sram_wr <= 1'b1;
              if (load_addr == secl_pkg::LAST_ADDR) begin
                loading <= 1'b0;
                loaded  <= 1'b1;
                state   <= secl_pkg::ST_IDLE;
              end else begin
                state <= secl_pkg::ST_LOAD;
              end
            end
          end else begin
            push  <= 1'b1;
            state <= secl_pkg::ST_IDLE;
          end
        end
        default: begin
          ee_sel_out <= 1'b0;
          state      <= secl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Load address advances on the same edge that writes the byte.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      load_addr <= secl_pkg::SIG_ADDR;
    end else if (ce_in && sram_wr) begin
      load_addr <= load_addr + 9'h001;
    end
  end

  // ---------------------------------------------------------------------------
  // Status and image fields
  // ---------------------------------------------------------------------------
  logic       present;
  logic [7:0] len_raw;
  logic [7:0] off_raw;

  // Presence follows the first byte of each load.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      present <= 1'b0;
      len_raw <= 8'h00;
      off_raw <= 8'h00;
    end else if (ce_in && sram_wr) begin
      if (load_addr == secl_pkg::SIG_ADDR) begin
        present <= 1'b1;
      end
      if (load_addr == secl_pkg::SWCFG_LEN_AD) begin
        len_raw <= rx;
      end
      if (load_addr == secl_pkg::SWCFG_OFF_AD) begin
        off_raw <= rx;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phy_disconnect_out <= 1'b1;
      ee_present_out     <= 1'b0;
      desc_default_out   <= 1'b1;
      swcfg_present_out  <= 1'b0;
      swcfg_len_out      <= secl_pkg::SWCFG_LEN_DF;
      swcfg_addr_out     <= secl_pkg::SWCFG_ADR_DF;
    end else if (ce_in) begin
      phy_disconnect_out <= !loaded;
      ee_present_out     <= present;
      desc_default_out   <= !present;
      swcfg_present_out  <= present && (len_raw != 8'h00);
      swcfg_len_out      <= (present && len_raw != 8'h00) ? len_raw : secl_pkg::SWCFG_LEN_DF;
      swcfg_addr_out     <= (present && len_raw != 8'h00) ? {off_raw, 1'b0}
                                                         : secl_pkg::SWCFG_ADR_DF;
    end
  end

  // ---------------------------------------------------------------------------
  // SRAM copy and descriptor port
  // ---------------------------------------------------------------------------
  // descriptors from SRAM
  secl_sram u_sram (
    .clk_in    (clk_in),
    .ce_in     (ce_in),
    .wr_in     (sram_wr),
    .waddr_in  (load_addr),
    .wdata_in  (rx),
    .rd_in     (desc_rd_in),
    .raddr_in  (desc_addr_in),
    .rdata_out (desc_rdata_out)
  );

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      desc_rvalid_out <= 1'b0;
    end else if (ce_in) begin
      desc_rvalid_out <= desc_rd_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Two-entry read answer buffer
  // ---------------------------------------------------------------------------
  // New host requests stall while the buffer is full, so no answer is dropped.
  logic [7:0] fifo [0:1];
  logic       wptr;
  logic       rptr;
  logic [1:0] count;
  logic       pop;

  assign fifo_full       = (count == 2'h2);
  assign host_rvalid_out = (count != 2'h0);
  assign pop             = host_rvalid_out && host_rready_in;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wptr    <= 1'b0;
      rptr    <= 1'b0;
      count   <= 2'h0;
      fifo[0] <= 8'h00;
      fifo[1] <= 8'h00;
    end else if (ce_in) begin
      if (push) begin
        fifo[wptr] <= rx;
        wptr       <= !wptr;
      end
      if (pop) begin
        rptr <= !rptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  assign host_rdata_out = fifo[rptr];

endmodule : secl_loader

/* verilog/secl_pkg.sv */
// Constants, timing and state types shared by the configuration loader files.
package secl_pkg;

  // ---------------------------------------------------------------------------
  // Clock and serial memory timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 5000;   // System clock period, 200 MHz.
  localparam int EE_HALF_NS     = 500;    // Least half period of the memory clock.
  localparam int EE_HALF_CYC    = (EE_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EE_BUSY_MS     = 10;     // Longest self-timed programming cycle.
  localparam int EE_BUSY_CYC    = (EE_BUSY_MS * 1000000 / CLK_PERIOD_PS) * 1000;

  // ---------------------------------------------------------------------------
  // Image layout
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W       = 9;       // 512 byte locations.
  localparam int          DEPTH        = 512;
  localparam logic [8:0]  LAST_ADDR    = 9'h1FF;
  localparam logic [7:0]  SIGNATURE    = 8'hA5;
  localparam logic [8:0]  SIG_ADDR     = 9'h000;
  localparam logic [8:0]  SWCFG_LEN_AD = 9'h014;  // Structure length, in bytes.
  localparam logic [8:0]  SWCFG_OFF_AD = 9'h015;  // Structure offset, in 16-bit words.
  localparam logic [7:0]  SWCFG_LEN_DF = 8'h00;   // Built-in default length.
  localparam logic [8:0]  SWCFG_ADR_DF = 9'h000;  // Built-in default byte address.

  // ---------------------------------------------------------------------------
  // Serial frames: start bit and opcode, then address, then data
  // ---------------------------------------------------------------------------
  localparam int          FRAME_W      = 20;
  localparam logic [2:0]  OPC_READ     = 3'h6;
  localparam logic [2:0]  OPC_WRITE    = 3'h5;
  localparam logic [2:0]  OPC_ERASE    = 3'h7;
  localparam logic [2:0]  OPC_EWEN     = 3'h4;
  localparam logic [8:0]  EWEN_ADDR    = 9'h180;  // Address bits 11 then don't care.
  localparam logic [4:0]  CLKS_SHORT   = 5'h0C;   // Start, opcode and address.
  localparam logic [4:0]  CLKS_LONG    = 5'h14;   // Plus one data byte.

  // Host operation codes.
  localparam logic [1:0]  HOP_READ     = 2'h0;
  localparam logic [1:0]  HOP_WRITE    = 2'h1;
  localparam logic [1:0]  HOP_ERASE    = 2'h2;

  typedef enum logic [2:0] {
    ST_LOAD  = 3'b000,
    ST_IDLE  = 3'b001,
    ST_XFER  = 3'b010,
    ST_GAP   = 3'b011,
    ST_POLL  = 3'b100,
    ST_DONE  = 3'b101
  } secl_state_e;

endpackage : secl_pkg

/* verilog/secl_sram.sv */
// Internal 512 byte copy of the configuration image with a registered read port.
`timescale 1ns/100ps

module secl_sram (
  input  wire logic       clk_in,
  input  wire logic       ce_in,
  input  wire logic       wr_in,
  input  wire logic [8:0] waddr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       rd_in,
  input  wire logic [8:0] raddr_in,
  output logic      [7:0] rdata_out
);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [7:0] mem [0:secl_pkg::DEPTH-1];

  // Write port, filled only by the loader.
  always_ff @(posedge clk_in) begin
    if (ce_in && wr_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // Read data come from a register, so the array maps to block memory.
  always_ff @(posedge clk_in) begin
    if (ce_in && rd_in) begin
      rdata_out <= mem[raddr_in];
    end
  end

endmodule : secl_sram
